/* eeprom_pkg.sv */
/*
 serial eeprom controller: shared constants, command codes, timing.
 assumes a 200 MHz system clock and a 128 x 8 three-wire eeprom.
*/
package eeprom_pkg;
    // image marker found at location zero
    localparam logic [7:0] SIG_VALUE    = 8'hA5;
    localparam int         STADDR_BYTES = 6;      // station address bytes
    localparam int         LOC_W        = 7;      // 128 locations
    localparam int         HDR_W        = 10;     // start + opcode + location
    localparam logic [4:0] LEN_SHORT    = 5'h0A;  // serial clocks, no data
    localparam logic [4:0] LEN_LONG     = 5'h12;  // serial clocks, with data
    // host command codes
    typedef enum logic [2:0] {
        CMD_READ   = 3'h0,
        CMD_EW_DIS = 3'h1,
        CMD_EW_EN  = 3'h2,
        CMD_WRITE  = 3'h3,
        CMD_WR_ALL = 3'h4,
        CMD_ERASE  = 3'h5,
        CMD_ER_ALL = 3'h6,
        CMD_RELOAD = 3'h7
    } cmd_t;
    // wire opcodes and extended selectors
    localparam logic [1:0] OPC_EXT   = 2'h0;
    localparam logic [1:0] OPC_WRITE = 2'h1;
    localparam logic [1:0] OPC_READ  = 2'h2;
    localparam logic [1:0] OPC_ERASE = 2'h3;
    localparam logic [1:0] EXT_EW_DIS = 2'h0;
    localparam logic [1:0] EXT_WR_ALL = 2'h1;
    localparam logic [1:0] EXT_ER_ALL = 2'h2;
    localparam logic [1:0] EXT_EW_EN  = 2'h3;
    // response timeout
    localparam int T_TIMEOUT_MS = 30;
    localparam int CLK_KHZ      = 200000;
    localparam int TIMEOUT_CYC  = T_TIMEOUT_MS * CLK_KHZ;
    localparam int TMO_W        = 23;
endpackage

/* eeprom_link.sv */
/*
 serial shifter on the link clock: frames one eeprom transaction.
 assumes request words stay stable from request toggle to done toggle.
*/
`timescale 1ns/10ps
`default_nettype none
module eeprom_link
    import eeprom_pkg::*;
(
    input  wire logic             link_clk_i,
    input  wire logic             reset_i,
    input  wire logic             req_tgl_i,
    input  wire logic             abort_i,
    input  wire logic [HDR_W-1:0] hdr_i,
    input  wire logic [7:0]       wdata_i,
    input  wire logic             long_i,
    input  wire logic             rd_op_i,
    input  wire logic             poll_i,
    input  wire logic             sdata_i,
    output logic                  done_tgl_o,
    output logic [7:0]            rdata_o,
    output logic                  sclk_o,
    output logic                  cs_o,
    output logic                  sdo_o,
    output logic                  oe_o
);
    typedef enum logic [2:0] {
        L_IDLE = 3'h0, L_SHIFT = 3'h1, L_GAP = 3'h2, L_POLL = 3'h3, L_DONE = 3'h4
    } lst_t;
    logic [1:0] rs_q, rq_q, ab_q, di_q;  // sync chains, bit 0 first flop
    logic       rst;                     // reset seen in link domain
    lst_t       st_q, st_d;
    logic [4:0] bit_q, bit_d;            // serial clock index
    logic       ph_q, ph_d;              // high half of serial clock
    logic [17:0] sh_q, sh_d;             // outgoing bits, msb first
    logic [7:0] rd_q, rd_d;              // incoming data byte
    logic       cs_q, cs_d, ck_q, ck_d, so_q, so_d, oe_q, oe_d, dn_q, dn_d;
    logic       seen_q, seen_d;          // last request toggle served
    logic [4:0] len;
    assign rst = rs_q[1];
    assign len = long_i ? LEN_LONG : LEN_SHORT;
    // synchronisers: first flop feeds only the second
    always_ff @(posedge link_clk_i) begin
        rs_q <= {rs_q[0], reset_i};
        rq_q <= {rq_q[0], req_tgl_i};
        ab_q <= {ab_q[0], abort_i};
        di_q <= {di_q[0], sdata_i};
    end
    // frame sequencer next state
    always_comb begin
        st_d = st_q; bit_d = bit_q; ph_d = ph_q; sh_d = sh_q; rd_d = rd_q;
        cs_d = cs_q; ck_d = ck_q; so_d = so_q; oe_d = oe_q; dn_d = dn_q;
        seen_d = seen_q;
        unique case (st_q)
            L_IDLE: begin
                if (rq_q[1] != seen_q) begin
                    seen_d = rq_q[1];
                    sh_d = {hdr_i, wdata_i};
                    so_d = hdr_i[HDR_W-1];
                    cs_d = 1'b1; oe_d = 1'b1; bit_d = 5'h00; ph_d = 1'b0;
                    st_d = L_SHIFT;
                end
            end
            L_SHIFT: begin
                if (!ph_q) begin
                    ck_d = 1'b1; ph_d = 1'b1;  // eeprom samples on rise
                end else begin
                    ck_d = 1'b0; ph_d = 1'b0;
                    // pin runs two flops behind: take the bit of the
                    // previous clock, the last one after the frame
                    if (rd_op_i && bit_q > 5'(HDR_W))
                        rd_d = {rd_q[6:0], di_q[1]};
                    if (bit_q == len - 5'h01) begin
                        cs_d = 1'b0; oe_d = 1'b0; st_d = L_GAP;
                    end else begin
                        bit_d = bit_q + 5'h01;
                        sh_d = {sh_q[16:0], 1'b0};
                        so_d = sh_q[16];
                        // release the line while the eeprom sends data
                        oe_d = !(rd_op_i && bit_q >= 5'(HDR_W - 1));
                    end
                end
            end
            L_GAP: begin
                cs_d = poll_i; so_d = 1'b0; bit_d = 5'h00;
                st_d = poll_i ? L_POLL : L_DONE;
            end
            L_POLL: begin
                // stale line values still sit in the synchroniser
                if (ab_q[1]) begin
                    cs_d = 1'b0; st_d = L_DONE;
                end else if (bit_q != 5'h03) begin
                    bit_d = bit_q + 5'h01;
                end else if (di_q[1]) begin
                    cs_d = 1'b0; st_d = L_DONE;
                end
            end
            L_DONE: begin
                // final data bit of a read lands here
                if (rd_op_i) begin
                    rd_d = {rd_q[6:0], di_q[1]};
                end
                dn_d = ~dn_q; st_d = L_IDLE;
            end
            default: st_d = L_IDLE;
        endcase
    end
    // frame sequencer registers
    always_ff @(posedge link_clk_i) begin
        if (rst) begin
            st_q <= L_IDLE; bit_q <= 5'h00; ph_q <= 1'b0; sh_q <= 18'h00000;
            rd_q <= 8'h00; cs_q <= 1'b0; ck_q <= 1'b0; so_q <= 1'b0;
            oe_q <= 1'b0; dn_q <= 1'b0; seen_q <= 1'b0;
        end else begin
            st_q <= st_d; bit_q <= bit_d; ph_q <= ph_d; sh_q <= sh_d;
            rd_q <= rd_d; cs_q <= cs_d; ck_q <= ck_d; so_q <= so_d;
            oe_q <= oe_d; dn_q <= dn_d; seen_q <= seen_d;
        end
    end
    assign done_tgl_o = dn_q;
    assign rdata_o = rd_q;
    assign sclk_o = ck_q;
    assign cs_o = cs_q;
    assign sdo_o = so_q;
    assign oe_o = oe_q;
    property p_start_bit;
        @(posedge link_clk_i) disable iff (rst)
        $rose(cs_q) && st_q == L_SHIFT |-> so_q && oe_q;
    endproperty
    a_start_bit: assert property (p_start_bit) else $error("frame not opened by start bit");
    property p_len;
        @(posedge link_clk_i) disable iff (rst)
        st_q == L_SHIFT && ph_q && bit_q == len - 5'h01 |=> st_q == L_GAP && !cs_q;
    endproperty
    a_len: assert property (p_len) else $error("frame length wrong");
endmodule
`default_nettype wire

/* eeprom_ctrl.sv */
/*
 serial eeprom controller: autoload of the station address, host
 commands with busy handshake, timeout and pin reuse.
 assumes a free running link clock and host strobes on CLOCK_I.
*/
`timescale 1ns/10ps
`default_nettype none
module eeprom_ctrl
    import eeprom_pkg::*;
#(
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYC  // response limit in clocks
)(
    input  wire logic              CLOCK_I,
    input  wire logic              RESET_I,
    input  wire logic              CE_I,
    input  wire logic              LINK_CLK_I,
    input  wire logic              CMD_WR_I,
    input  wire logic [2:0]        CMD_CODE_I,
    input  wire logic [LOC_W-1:0]  CMD_LOC_I,
    input  wire logic              CMD_BUSY_I,
    input  wire logic              DATA_WR_I,
    input  wire logic [7:0]        DATA_I,
    input  wire logic              TMO_CLR_I,
    input  wire logic              SOFT_RESET_I,
    input  wire logic              STADDR_WR_I,
    input  wire logic [47:0]       STADDR_I,
    input  wire logic              IF_DISABLE_I,
    input  wire logic              MON_SEL_I,
    input  wire logic [1:0]        GPO_I,
    input  wire logic [1:0]        MII_MON_I,
    input  wire logic              SDATA_I,
    output logic [2:0]             CMD_CODE_O,
    output logic [LOC_W-1:0]       CMD_LOC_O,
    output logic                   CMD_BUSY_O,
    output logic                   TIMEOUT_O,
    output logic                   ADDR_LOADED_O,
    output logic [7:0]             DATA_O,
    output logic [47:0]            STADDR_O,
    output logic                   SCLK_O,
    output logic                   CS_O,
    output logic                   SDATA_O,
    output logic                   SDATA_OE_O
);
    // a limit the counter cannot reach is refused
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 2 ** TMO_W) begin : g_chk
        $error("TIMEOUT_CYCLES out of range");
    end
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT_CYCLES - 1);

    typedef enum logic [1:0] {
        S_IDLE  = 2'h0,  // waiting for host
        S_ISSUE = 2'h1,  // hand request to link
        S_WAIT  = 2'h2,  // link busy, timer runs
        S_ABORT = 2'h3   // timed out, waiting for link to stop
    } st_t;

    st_t              st_q, st_d;       // controller state
    cmd_t             op_q, op_d;       // command code field
    logic [LOC_W-1:0] loc_q, loc_d;     // location field
    logic [7:0]       data_q, data_d;   // data register
    logic             busy_q, busy_d;   // busy bit
    logic             tmo_q, tmo_d;     // timeout flag
    logic             ldd_q, ldd_d;     // address loaded flag
    logic             ld_q, ld_d;       // address load in progress
    logic [2:0]       idx_q, idx_d;     // load step, 0 is marker
    logic             sig_q, sig_d;     // marker matched
    logic [47:0]      sta_q, sta_d;     // station address
    logic [TMO_W-1:0] cnt_q, cnt_d;     // response timer
    logic             rtg_q, rtg_d;     // request toggle to link
    logic             ab_q, ab_d;       // abort level to link

    logic [2:0]       dn_q;             // done toggle sync, bit 0 first
    logic [1:0]       mon1_q, mon2_q;   // monitor input sync
    logic [1:0]       pin_q;            // reused pin values

    logic             done_ev;          // link finished a frame
    logic             link_done;        // raw done toggle
    logic [7:0]       rdata;            // byte from link, stable at done
    logic [LOC_W-1:0] eff_loc;          // location sent
    logic [HDR_W-1:0] hdr;              // start, opcode, location
    logic             rd_op;            // frame returns data
    logic             long_op;          // frame carries data byte
    logic             poll_op;          // frame programs the array
    logic             lk_sclk, lk_cs, lk_sdo, lk_oe;

    // frame header from command
    function automatic logic [HDR_W-1:0] make_hdr(input cmd_t op,
                                                  input logic [LOC_W-1:0] loc);
        logic [1:0] opc;
        logic [LOC_W-1:0] a;
        opc = OPC_EXT;
        a   = loc;
        unique case (op)
            CMD_READ, CMD_RELOAD: opc = OPC_READ;
            CMD_WRITE:            opc = OPC_WRITE;
            CMD_ERASE:            opc = OPC_ERASE;
            CMD_EW_DIS:           a = {EXT_EW_DIS, 5'h00};
            CMD_EW_EN:            a = {EXT_EW_EN, 5'h00};
            CMD_ER_ALL:           a = {EXT_ER_ALL, 5'h00};
            CMD_WR_ALL:           a = {EXT_WR_ALL, 5'h00};
        endcase
        return {1'b1, opc, a};
    endfunction

    // the load walks locations 0..6 as plain reads
    assign eff_loc = ld_q ? {4'h0, idx_q} : loc_q;
    assign rd_op   = ld_q || op_q == CMD_READ;
    assign long_op = rd_op || op_q == CMD_WRITE || op_q == CMD_WR_ALL;
    assign poll_op = !ld_q && (op_q == CMD_WRITE || op_q == CMD_WR_ALL ||
                               op_q == CMD_ERASE || op_q == CMD_ER_ALL);
    assign hdr     = make_hdr(ld_q ? CMD_READ : op_q, eff_loc);
    // edge taken after the second flop only
    assign done_ev = dn_q[2] != dn_q[1];

    // link side shifter
    eeprom_link u_link (
        .link_clk_i (LINK_CLK_I),
        .reset_i    (RESET_I),
        .req_tgl_i  (rtg_q),
        .abort_i    (ab_q),
        .hdr_i      (hdr),
        .wdata_i    (data_q),
        .long_i     (long_op),
        .rd_op_i    (rd_op),
        .poll_i     (poll_op),
        .sdata_i    (SDATA_I),
        .done_tgl_o (link_done),
        .rdata_o    (rdata),
        .sclk_o     (lk_sclk),
        .cs_o       (lk_cs),
        .sdo_o      (lk_sdo),
        .oe_o       (lk_oe)
    );

    // controller next state
    always_comb begin
        st_d = st_q; op_d = op_q; loc_d = loc_q; data_d = data_q;
        busy_d = busy_q; tmo_d = tmo_q; ldd_d = ldd_q; ld_d = ld_q;
        idx_d = idx_q; sig_d = sig_q; sta_d = sta_q; cnt_d = cnt_q;
        rtg_d = rtg_q; ab_d = ab_q;
        // host clear first so a same cycle timeout wins
        if (TMO_CLR_I) begin
            tmo_d = 1'b0;
        end
        unique case (st_q)
            S_IDLE: begin
                // host writes other than the timeout clear land only while idle
                if (DATA_WR_I) begin
                    data_d = DATA_I;
                end
                if (STADDR_WR_I) begin
                    sta_d = STADDR_I;
                end
                if (SOFT_RESET_I) begin
                    ld_d = 1'b1; idx_d = 3'h0; ldd_d = 1'b0;
                    sig_d = 1'b0; busy_d = 1'b1; st_d = S_ISSUE;
                end else if (CMD_WR_I) begin
                    op_d  = cmd_t'(CMD_CODE_I);
                    loc_d = CMD_LOC_I;
                    if (CMD_BUSY_I) begin
                        busy_d = 1'b1;
                        st_d   = S_ISSUE;
                        if (cmd_t'(CMD_CODE_I) == CMD_RELOAD) begin
                            ld_d = 1'b1; idx_d = 3'h0; ldd_d = 1'b0;
                            sig_d = 1'b0;
                        end
                    end
                end
            end
            S_ISSUE: begin
                rtg_d = ~rtg_q;
                cnt_d = '0;
                st_d  = S_WAIT;
            end
            S_WAIT: begin
                if (done_ev) begin
                    if (ld_q && idx_q == 3'h0) begin
                        sig_d = rdata == SIG_VALUE;
                        if (rdata == SIG_VALUE) begin
                            idx_d = 3'h1; st_d = S_ISSUE;
                        end else begin
                            ld_d = 1'b0; busy_d = 1'b0; st_d = S_IDLE;
                        end
                    end else if (ld_q) begin
                        sta_d[8 * (int'(idx_q) - 1) +: 8] = rdata;
                        if (idx_q == 3'(STADDR_BYTES)) begin
                            ldd_d = 1'b1; ld_d = 1'b0;
                            busy_d = 1'b0; st_d = S_IDLE;
                        end else begin
                            idx_d = idx_q + 3'h1; st_d = S_ISSUE;
                        end
                    end else begin
                        if (op_q == CMD_READ) begin
                            data_d = rdata;
                        end
                        busy_d = 1'b0; st_d = S_IDLE;
                    end
                end else if (cnt_q == TMO_LAST) begin
                    tmo_d = 1'b1; ab_d = 1'b1; st_d = S_ABORT;
                end else begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            S_ABORT: begin
                // busy holds until the link has really let go
                if (done_ev) begin
                    ab_d = 1'b0; ld_d = 1'b0; busy_d = 1'b0; st_d = S_IDLE;
                end
            end
        endcase
    end

    // controller registers, reset starts the autoload
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            st_q <= S_ISSUE; op_q <= CMD_READ; loc_q <= '0;
            data_q <= 8'h00; busy_q <= 1'b1; tmo_q <= 1'b0;
            ldd_q <= 1'b0; ld_q <= 1'b1; idx_q <= 3'h0; sig_q <= 1'b0;
            sta_q <= 48'h000000000000; cnt_q <= '0;
            rtg_q <= 1'b0; ab_q <= 1'b0;
        end else if (CE_I) begin
            st_q <= st_d; op_q <= op_d; loc_q <= loc_d;
            data_q <= data_d; busy_q <= busy_d; tmo_q <= tmo_d;
            ldd_q <= ldd_d; ld_q <= ld_d; idx_q <= idx_d; sig_q <= sig_d;
            sta_q <= sta_d; cnt_q <= cnt_d;
            rtg_q <= rtg_d; ab_q <= ab_d;
        end
    end

    // crossings and reused pin values
    always_ff @(posedge CLOCK_I) begin
        if (RESET_I) begin
            dn_q <= 3'h0; mon1_q <= 2'h0; mon2_q <= 2'h0; pin_q <= 2'h0;
        end else if (CE_I) begin
            dn_q   <= {dn_q[1], dn_q[0], link_done};
            mon1_q <= MII_MON_I;
            mon2_q <= mon1_q;
            pin_q  <= MON_SEL_I ? mon2_q : GPO_I;
        end
    end

    // register views for the host
    assign CMD_CODE_O    = op_q;
    assign CMD_LOC_O     = loc_q;
    assign CMD_BUSY_O    = busy_q;
    assign TIMEOUT_O     = tmo_q;
    assign ADDR_LOADED_O = ldd_q;
    assign DATA_O        = data_q;
    assign STADDR_O      = sta_q;
    assign SCLK_O     = IF_DISABLE_I ? pin_q[1] : lk_sclk;
    assign CS_O       = !IF_DISABLE_I && lk_cs;
    assign SDATA_O    = IF_DISABLE_I ? pin_q[0] : lk_sdo;
    assign SDATA_OE_O = IF_DISABLE_I || lk_oe;

    // checks
    property p_boot;
        @(posedge CLOCK_I) disable iff (RESET_I)
        $past(RESET_I) |-> busy_q && ld_q && idx_q == 3'h0 && st_q == S_ISSUE;
    endproperty
    a_boot: assert property (p_boot) else $error("no load after reset");
    property p_sig;
        @(posedge CLOCK_I) disable iff (RESET_I)
        ld_q && idx_q != 3'h0 |-> sig_q;
    endproperty
    a_sig: assert property (p_sig) else $error("load went on without marker");
    property p_step;
        @(posedge CLOCK_I) disable iff (RESET_I)
        st_q == S_WAIT && done_ev && ld_q && sig_q && idx_q < 3'h6 && CE_I
        |=> idx_q == $past(idx_q) + 3'h1 ##1 st_q == S_WAIT;
    endproperty
    a_step: assert property (p_step) else $error("address byte step wrong");
    sequence s_last;
        st_q == S_WAIT && done_ev && ld_q && idx_q == 3'h6 && CE_I;
    endsequence
    property p_loaded;
        @(posedge CLOCK_I) disable iff (RESET_I)
        s_last |=> ldd_q && !busy_q && sta_q[47:40] == $past(rdata);
    endproperty
    a_loaded: assert property (p_loaded) else $error("loaded flag or last byte wrong");
    property p_nosig;
        @(posedge CLOCK_I) disable iff (RESET_I)
        st_q == S_WAIT && done_ev && ld_q && idx_q == 3'h0 && rdata != SIG_VALUE && CE_I
        |=> $stable(sta_q) && !ldd_q && !busy_q;
    endproperty
    a_nosig: assert property (p_nosig) else $error("bad marker not handled");
    property p_done;
        @(posedge CLOCK_I) disable iff (RESET_I)
        $fell(busy_q) |-> $past(done_ev) && ($past(st_q) == S_WAIT || $past(st_q) == S_ABORT);
    endproperty
    a_done: assert property (p_done) else $error("busy fell without completion");
    property p_read;
        @(posedge CLOCK_I) disable iff (RESET_I)
        st_q == S_WAIT && done_ev && !ld_q && op_q == CMD_READ && CE_I
        |=> DATA_O == $past(rdata) && !CMD_BUSY_O;
    endproperty
    a_read: assert property (p_read) else $error("read byte not held");
    property p_tmo;
        @(posedge CLOCK_I) disable iff (RESET_I)
        st_q == S_WAIT && cnt_q == TMO_LAST && !done_ev && CE_I
        |=> TIMEOUT_O && st_q == S_ABORT;
    endproperty
    a_tmo: assert property (p_tmo) else $error("timeout not flagged");
    property p_dis;
        @(posedge CLOCK_I) disable iff (RESET_I)
        IF_DISABLE_I |-> SDATA_OE_O && !CS_O && SCLK_O == pin_q[1];
    endproperty
    a_dis: assert property (p_dis) else $error("pins still serve eeprom");
endmodule
`default_nettype wire

/* eeprom_model.sv */
/* partner model: a 128 x 8 three-wire eeprom.
 assumes the bench merges its data line with the controller's. */
`timescale 1ns/10ps
`default_nettype none
module eeprom_model(
    input  wire logic sclk_i,
    input  wire logic cs_i,
    input  wire logic di_i,
    input  wire logic stall_i,
    output logic      do_o
);
    logic [7:0] mem [128];  // cell array
    logic [9:0] sh;         // bits shifted in
    logic [9:0] hdr;        // start, opcode, location
    int         n;          // serial clocks in frame
    bit         we;         // erase/write enabled
    bit         prog;       // ready poll due
    initial begin
        we = 0;
        prog = 0;
        n = 0;
        do_o = 1;
    end
    // ready poll after programming
    // stall never answers
    always @(posedge cs_i) begin
        n = 0;
        if (prog) begin
            prog = 0;
            do_o = 0;
            if (!stall_i) #90 do_o = 1;
        end
    end
    // ten header clocks, data out on 11..18
    always @(posedge sclk_i) if (cs_i) begin
        n = n + 1;
        sh = {sh[8:0], di_i};
        if (n == 10) hdr = sh;
        if (n > 10 && hdr[8:7] == 2'h2) do_o = mem[hdr[6:0]][18-n];
        else do_o = ~do_o;  // not driving: never a steady stale level
    end
    always @(negedge cs_i) if (n >= 10) begin
        case (hdr[8:7])
            2'h0: case (hdr[6:5])
                2'h0: we = 0;
                2'h3: we = 1;
                2'h1: if (we) for (int i = 0; i < 128; i++) mem[i] = sh[7:0];
                default: if (we) for (int i = 0; i < 128; i++) mem[i] = 8'hFF;
            endcase
            2'h1: if (we) mem[hdr[6:0]] = sh[7:0];
            2'h3: if (we) mem[hdr[6:0]] = 8'hFF;
            default: ;
        endcase
        prog = hdr[8:7] == 2'h1 || hdr[8:7] == 2'h3 || (hdr[8:7] == 2'h0 && hdr[6] != hdr[5]);
    end
endmodule
`default_nettype wire

/* serial_eeprom_controller_tb_top.sv */
/* self-checking bench for the eeprom controller.
 assumes the partner model sits on the serial pins. */
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_controller_tb_top;
    import eeprom_pkg::*;
    logic clk, rst, lclk, wr, bsy, dwr, tclr, srst, dis, stall, edo, ce, msel;
    logic [2:0] code;
    logic [6:0] loc;
    logic [7:0] din, dout;
    logic [1:0] gpo, mon;
    logic bsy_o, tmo, ldd, sclk, cs, sdo, oe;
    logic [47:0] sta;
    int mismatches = 0;
    int n_compared = 0;
    wire logic sdi = oe ? sdo : edo;  // shared data wire
    logic [2:0] sc [8] = '{3'h2, 3'h3, 3'h5, 3'h1, 3'h3, 3'h2, 3'h4, 3'h6};
    logic [7:0] sd [8] = '{8'h00, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h5A, 8'h00};
    logic [6:0] sl [8] = '{7'h7F, 7'h05, 7'h05, 7'h05, 7'h05, 7'h05, 7'h7F, 7'h00};
    logic [7:0] se [8] = '{8'h7F, 8'h3C, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'hFF};
    eeprom_ctrl #(.TIMEOUT_CYCLES(2000)) uut(.CLOCK_I(clk), .RESET_I(rst), .CE_I(ce),
        .LINK_CLK_I(lclk), .CMD_WR_I(wr), .CMD_CODE_I(code), .CMD_LOC_I(loc), .CMD_BUSY_I(bsy),
        .DATA_WR_I(dwr), .DATA_I(din), .TMO_CLR_I(tclr), .SOFT_RESET_I(srst), .STADDR_WR_I(1'b0),
        .STADDR_I(48'h0), .IF_DISABLE_I(dis), .MON_SEL_I(msel), .GPO_I(gpo), .MII_MON_I(mon),
        .SDATA_I(sdi), .CMD_CODE_O(), .CMD_LOC_O(), .CMD_BUSY_O(bsy_o), .TIMEOUT_O(tmo),
        .ADDR_LOADED_O(ldd), .DATA_O(dout), .STADDR_O(sta), .SCLK_O(sclk), .CS_O(cs),
        .SDATA_O(sdo), .SDATA_OE_O(oe));
    eeprom_model ee(.sclk_i(sclk), .cs_i(cs), .di_i(sdo), .stall_i(stall), .do_o(edo));
    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        lclk = 0;
        #3.3;
        forever #6 lclk = ~lclk;
    end
    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // bounded wait for busy to drop
    task automatic wait_idle;
        int k;
        for (k = 0; k < 20000 && bsy_o !== 1'b0; k++) @(negedge clk);
        if (k == 20000) begin
            mismatches++;
            conclude();
        end
    endtask
    task automatic cmd(input logic [2:0] c, input logic [6:0] a, input logic [7:0] d);
        din = d;
        dwr = 1;
        @(negedge clk);
        {dwr, code, loc, bsy, wr} = {1'b0, c, a, 2'b11};
        @(negedge clk);
        {bsy, wr} = 2'b00;
        // next write only once busy clears
        wait_idle();
    endtask
    task automatic t_autoload;
        wait_idle();
        check(sta, 48'h060504030201);
        check(ldd, 1'b1);
    endtask
    // enable precedes programming, each op read back
    task automatic t_ops;
        for (int i = 0; i < 8; i++) begin
            cmd(sc[i], sl[i], sd[i]);
            cmd(CMD_READ, sl[i], 8'h00);
            check(dout, se[i]);
        end
    endtask
    // erased marker fails the load, a restored one passes
    task automatic t_fail_load;
        srst = 1;
        @(negedge clk);
        srst = 0;
        wait_idle();
        check(sta, 48'h060504030201);
        check(ldd, 1'b0);
        cmd(CMD_RELOAD, 7'h00, 8'h00);
        check(ldd, 1'b0);
        cmd(CMD_WRITE, 7'h00, SIG_VALUE);
        cmd(CMD_WRITE, 7'h01, 8'hC3);
        cmd(CMD_RELOAD, 7'h00, 8'h00);
        check(ldd, 1'b1);
        check(sta, 48'hFFFFFFFFFFC3);
    endtask
    // stalled poll times out; clear held off while enable is low
    task automatic t_timeout;
        stall = 1;
        cmd(CMD_WRITE, 7'h09, 8'h11);
        check(tmo, 1'b1);
        stall = 0;
        {ce, tclr} = 2'b01;
        @(negedge clk);
        check(tmo, 1'b1);
        ce = 1;
        @(negedge clk);
        tclr = 0;
        check(tmo, 1'b0);
    endtask
    // pins as general outputs, then as monitors
    task automatic t_disable;
        {dis, gpo} = 3'b110;
        repeat (4) @(negedge clk);
        check({sclk, cs, sdo, oe}, 4'h9);
        {msel, mon} = 3'b101;
        repeat (4) @(negedge clk);
        check({sclk, cs, sdo, oe}, 4'h3);
    endtask
    initial begin
        {wr, bsy, dwr, tclr, srst, dis, stall, msel} = 8'h00;
        {code, loc, din, gpo, mon} = 22'h000000;
        rst = 1;
        ce = 1;
        for (int i = 0; i < 128; i++) ee.mem[i] = i ? 8'(i) : SIG_VALUE;
        repeat (3) @(negedge clk);
        rst = 0;
        @(negedge clk);
        check(bsy_o, 1'b1);
        t_autoload();
        t_ops();
        t_fail_load();
        t_timeout();
        t_disable();
        conclude();
    end
endmodule
`default_nettype wire
